// ---- rtcmc_params.svh ----
// Constants for the RTC misc control block: offsets, bit positions, timing.
// Assumes a 125 MHz system clock and a byte-wide register port.
// Summary of operation
// - With rollover enable set, century flag inverts at each century turnover.
// - With test, alarm and watchdog all clear, pin follows control bit 7.
// - Pin level bit and freq test both zero drive the pin low.
// - Pin is open drain: it only pulls low or releases.
// - Battery checked at every power-up and about every 24 hours.
// - Battery below about 2.5 V sets battery weak flag, flags bit 4.
// - Battery weak flag holds until a later check passes.
// - Battery checks run only while main supply is present.
// - Clock register 04h bit 7 holds recovery time select.
// - Recovery time is 96-98 ms, 40-200 ms, or 50-2000 us by bits.
// - During recovery deselect, host-side inputs are ignored.
// - First power-up clears watchdog, enables and recovery select.
// - First power-up sets oscillator halt, pin level and halt update.
// - Later power-up keeps select, halt, level; sets halt update; clears rest.
// - Watchdog clear covers steering, five multiplier and two resolution bits.
// - Other control bits have no defined power-up value.
`ifndef RTCMC_PARAMS_SVH
`define RTCMC_PARAMS_SVH
`define RTCMC_ADDR_CENT 8'h03
`define RTCMC_ADDR_HOUR 8'h04
`define RTCMC_ADDR_CTRL 8'h08
`define RTCMC_ADDR_WDOG 8'h09
`define RTCMC_ADDR_ALRM 8'h0a
`define RTCMC_ADDR_FLAG 8'h0f
`define RTCMC_ADDR_HALT 8'h0c
`define RTCMC_ADDR_IST 8'h20
`define RTCMC_ADDR_IMSK 8'h21
`define RTCMC_ADDR_STAT 8'h22
`define RTCMC_BIT_HI 7
`define RTCMC_BIT_LO 6
`define RTCMC_BIT_BATT 4
`define RTCMC_BIT_ABE 5
`define RTCMC_CLK_MHZ 125
`define RTCMC_REC_LONG_MS 97
`define RTCMC_REC_HALT_MS 120
`define RTCMC_REC_SHORT_US 1000
`define RTCMC_CHECK_HOURS 24
`define RTCMC_YEAR_LAST 8'h99
`endif

// ---- rtcmc_pkg.sv ----
// Types for the RTC misc control block.
// Assumes rtcmc_params.svh supplies all numbers.
package rtcmc_pkg;
   typedef enum logic [2:0] {
      RTCMC_OFF = 3'b001,
      RTCMC_REC = 3'b010,
      RTCMC_RUN = 3'b100
   } rtcmc_state_t;
   typedef struct packed {
      rtcmc_state_t st;
      logic [31:0] rec_cnt;
      logic [47:0] day_cnt;
      logic ever_up;
      logic cent_en;
      logic cent_flag;
      logic rec_sel;
      logic osc_halt;
      logic halt_upd;
      logic pin_level;
      logic freq_test;
      logic alarm_en;
      logic alarm_bk;
      logic sqw_en;
      logic [7:0] wdog;
      logic batt_weak;
      logic batt_req;
      logic [1:0] ist;
      logic [1:0] imsk;
      logic [7:0] rdata;
   } rtcmc_regs_t;
endpackage

// ---- rtcmc_core.sv ----
// Misc control of a serial RTC: century flag, open-drain pin, battery
// monitor, recovery deselect timing and power-up defaults.
// Assumes supply, battery and year-wrap levels come from analog/counter
// logic; pin and comparator inputs come unsynchronised.
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "rtcmc_params.svh"
module rtcmc_core import rtcmc_pkg::*; #(
   parameter int REC_LONG_CYC = `RTCMC_REC_LONG_MS * 1000 * `RTCMC_CLK_MHZ,
   parameter int REC_HALT_CYC = `RTCMC_REC_HALT_MS * 1000 * `RTCMC_CLK_MHZ,
   parameter int REC_SHORT_CYC = `RTCMC_REC_SHORT_US * `RTCMC_CLK_MHZ,
   parameter longint CHECK_CYC =
      64'(`RTCMC_CHECK_HOURS) * 3600 * 1000000 * `RTCMC_CLK_MHZ
) (
   input wire logic clk, // 125 MHz clock
   input wire logic sys_rst, // Sync reset, high
   input wire logic supply_ok, // Main supply above threshold, async
   input wire logic batt_low, // Battery comparator below 2.5 V, async
   input wire logic year_wrap, // One-cycle pulse, year 99 to 00
   input wire logic [7:0] addr, // Register address
   input wire logic [7:0] wdata, // Write data
   input wire logic wr_stb, // Write strobe
   input wire logic rd_stb, // Read strobe
   output logic [7:0] rdata, // Read data, cycle after strobe
   output logic mf_pin_o, // Pin drive level, always 0
   output logic mf_pin_oe, // Pin pull-low enable
   output logic host_enable, // High once recovery deselect ended
   output logic irq // Level interrupt
);
   rtcmc_regs_t r_reg, r_next;
   logic sup_now, bat_now;
   logic wr_ok, rd_ok;
   logic [31:0] rec_len;
   logic due;

   // Register map seen from the host port:
   // 03h bit 7 rollover enable, bit 6 century flag
   // 04h bit 7 recovery time select
   // 08h bit 7 pin level, bit 6 frequency test enable
   // 09h watchdog byte: steering, multiplier, resolution
   // 0Ah bit 7 alarm flag enable, bit 6 square wave, bit 5 alarm backup
   // 0Ch bit 6 halt update flag
   // 0Fh bit 4 battery weak flag, read only
   // 20h sticky events, write one to clear: bit 0 weak, bit 1 ready
   // 21h event mask, same layout
   // 22h one-hot state: off, deselect, run
   // Every write and read is dropped until deselect has ended, so a
   // host that boots faster than the supply settles cannot corrupt bits.

   // State walk: off until supply is seen, then deselect for the
   // chosen length, then run. Supply loss returns to off from either.
   // The power-up defaults are applied on the off to deselect step,
   // which is why first power-up is told apart by the ever_up bit.
   // A limitation: the long recovery count is over twelve million
   // cycles, so benches shorten it through the parameters.

   // Battery check due: pending request while powered
   function automatic logic check_due(input rtcmc_regs_t r, input logic s);
      return r.batt_req && s && (r.st != RTCMC_OFF);
   endfunction
   assign due = check_due(r_reg, sup_now);

   // Pin inputs cross from outside; one identical chain per input
   localparam int N_SYNC = 2;
   logic [N_SYNC-1:0] async_in, sync_out;
   assign async_in = {batt_low, supply_ok};
   genvar gi;
   generate
      for (gi = 0; gi < N_SYNC; gi++) begin : g_sync
         logic [2:0] stage;
         logic held;
         // A level counts once stages two and three agree, so one
         // metastable sample cannot start or end a power cycle
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               stage <= 3'h0;
               held <= 1'b0;
            end else begin
               stage <= {stage[1:0], async_in[gi]};
               if (stage[1] == stage[2]) held <= stage[2];
            end
         end
         assign sync_out[gi] = held;
      end
   endgenerate
   assign sup_now = sync_out[0];
   assign bat_now = sync_out[1];

   // recovery length picked from select and halt bits
   always_comb begin
      if (r_reg.rec_sel) rec_len = REC_SHORT_CYC;
      else if (r_reg.osc_halt) rec_len = REC_HALT_CYC;
      else rec_len = REC_LONG_CYC;
   end

   // host strobes count only in the run state
   assign wr_ok = wr_stb && (r_reg.st == RTCMC_RUN);
   assign rd_ok = rd_stb && (r_reg.st == RTCMC_RUN);

   // Next-state logic for all block state
   always_comb begin
      r_next = r_reg;
      r_next.rdata = 8'h00;
      unique case (r_reg.st)
         RTCMC_OFF: begin
            if (sup_now) begin
               r_next.st = RTCMC_REC;
               r_next.rec_cnt = 32'h0;
               r_next.batt_req = 1'b1;
               // first power-up sets halt and pin level
               if (!r_reg.ever_up) begin
                  r_next.osc_halt = 1'b1;
                  r_next.pin_level = 1'b1;
                  r_next.rec_sel = 1'b0;
               end
               // halt update set, enables and watchdog cleared
               r_next.ever_up = 1'b1;
               r_next.halt_upd = 1'b1;
               r_next.freq_test = 1'b0;
               r_next.alarm_en = 1'b0;
               r_next.alarm_bk = 1'b0;
               r_next.sqw_en = 1'b0;
               r_next.wdog = 8'h00;
            end
         end
         RTCMC_REC: begin
            // deselect lasts its chosen time after supply recovers
            if (!sup_now) r_next.st = RTCMC_OFF;
            else if (r_reg.rec_cnt >= rec_len - 32'h1) begin
               r_next.st = RTCMC_RUN;
               r_next.day_cnt = 48'h0;
            end else r_next.rec_cnt = r_reg.rec_cnt + 32'h1;
         end
         RTCMC_RUN: begin
            if (!sup_now) r_next.st = RTCMC_OFF;
            else if (r_reg.day_cnt >= 48'(CHECK_CYC - 1)) begin
               r_next.day_cnt = 48'h0;
               r_next.batt_req = 1'b1;
            end else r_next.day_cnt = r_reg.day_cnt + 48'h1;
         end
         default: r_next.st = RTCMC_OFF;
      endcase
      // checks only with main supply present
      if (due) begin
         r_next.batt_req = 1'b0;
         r_next.batt_weak = bat_now;
         if (bat_now) r_next.ist[0] = 1'b1;
      end
      // Register writes from the host
      if (wr_ok) begin
         unique case (addr)
            `RTCMC_ADDR_CENT: begin
               r_next.cent_en = wdata[`RTCMC_BIT_HI];
               r_next.cent_flag = wdata[`RTCMC_BIT_LO];
            end
            // recovery select lives in 04h bit 7
            `RTCMC_ADDR_HOUR: r_next.rec_sel = wdata[`RTCMC_BIT_HI];
            `RTCMC_ADDR_CTRL: begin
               r_next.pin_level = wdata[`RTCMC_BIT_HI];
               r_next.freq_test = wdata[`RTCMC_BIT_LO];
            end
            `RTCMC_ADDR_WDOG: r_next.wdog = wdata;
            `RTCMC_ADDR_ALRM: begin
               r_next.alarm_en = wdata[`RTCMC_BIT_HI];
               r_next.sqw_en = wdata[`RTCMC_BIT_LO];
               r_next.alarm_bk = wdata[`RTCMC_BIT_ABE];
            end
            `RTCMC_ADDR_HALT: r_next.halt_upd = wdata[`RTCMC_BIT_LO];
            `RTCMC_ADDR_IMSK: r_next.imsk = wdata[1:0];
            default: ;
         endcase
      end
      // century flag toggles on year wrap, inverting a same-cycle write
      if (year_wrap && r_reg.cent_en) r_next.cent_flag = ~r_next.cent_flag;
      // Write-one clear; events set in the same cycle still win
      if (wr_ok && addr == `RTCMC_ADDR_IST)
         r_next.ist = r_reg.ist & ~wdata[1:0];
      if (r_reg.st == RTCMC_REC && r_next.st == RTCMC_RUN)
         r_next.ist[1] = 1'b1;
      if (due && bat_now)
         r_next.ist[0] = 1'b1;
      // Reads, data valid in the following cycle
      if (rd_ok) begin
         unique case (addr)
            `RTCMC_ADDR_CENT:
               r_next.rdata = {r_reg.cent_en, r_reg.cent_flag, 6'h00};
            `RTCMC_ADDR_HOUR: r_next.rdata = {r_reg.rec_sel, 7'h00};
            `RTCMC_ADDR_CTRL:
               r_next.rdata = {r_reg.pin_level, r_reg.freq_test, 6'h00};
            `RTCMC_ADDR_WDOG: r_next.rdata = r_reg.wdog;
            `RTCMC_ADDR_ALRM:
               r_next.rdata = {r_reg.alarm_en, r_reg.sqw_en,
                               r_reg.alarm_bk, 5'h00};
            `RTCMC_ADDR_HALT: r_next.rdata = {1'b0, r_reg.halt_upd, 6'h00};
            `RTCMC_ADDR_FLAG: r_next.rdata = {3'h0, r_reg.batt_weak, 4'h0};
            `RTCMC_ADDR_IST: r_next.rdata = {6'h00, r_reg.ist};
            `RTCMC_ADDR_IMSK: r_next.rdata = {6'h00, r_reg.imsk};
            `RTCMC_ADDR_STAT: r_next.rdata = {5'h00, r_reg.st};
            default: r_next.rdata = 8'h00;
         endcase
      end
   end

   // State register; sys_rst models power lost with no battery
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r_reg <= '0;
         r_reg.st <= RTCMC_OFF;
      end else r_reg <= r_next;
   end

   // pin: open drain, follows level bit when functions idle
   assign mf_pin_o = 1'b0;
   assign mf_pin_oe = !r_reg.freq_test && !r_reg.alarm_en &&
                      (r_reg.wdog == 8'h00) && !r_reg.pin_level;
   assign rdata = r_reg.rdata;
   assign host_enable = (r_reg.st == RTCMC_RUN);
   // Level interrupt from unmasked sticky events
   assign irq = |(r_reg.ist & r_reg.imsk);

   // no pin level change from a control write outside run state
   a_deselect_blocks: assert property (@(posedge clk) disable iff (sys_rst)
      (r_reg.st != RTCMC_RUN && wr_stb && addr == `RTCMC_ADDR_CTRL)
      |=> $stable(r_reg.pin_level)) else $error("write taken in deselect");
   a_century_toggle: assert property (@(posedge clk) disable iff (sys_rst)
      (year_wrap && r_reg.cent_en && !wr_ok)
      |=> r_reg.cent_flag != $past(r_reg.cent_flag))
      else $error("century flag did not toggle");
   a_century_hold: assert property (@(posedge clk) disable iff (sys_rst)
      (year_wrap && !r_reg.cent_en && !wr_ok) |=> $stable(r_reg.cent_flag))
      else $error("century flag changed while disabled");
   a_pin_low_drive: assert property (@(posedge clk) disable iff (sys_rst)
      (!r_reg.pin_level && !r_reg.freq_test && !r_reg.alarm_en &&
       r_reg.wdog == 8'h00) |-> mf_pin_oe) else $error("pin not pulled low");
   a_pin_open_drain: assert property (@(posedge clk) disable iff (sys_rst)
      mf_pin_o == 1'b0 && (r_reg.pin_level -> !mf_pin_oe))
      else $error("pin driven high");
   a_batt_only_up: assert property (@(posedge clk) disable iff (sys_rst)
      (r_reg.st == RTCMC_OFF && !sup_now) |=> $stable(r_reg.batt_weak))
      else $error("battery checked without supply");
   a_first_defaults: assert property (@(posedge clk) disable iff (sys_rst)
      (r_reg.st == RTCMC_OFF && sup_now && !r_reg.ever_up)
      |=> r_reg.osc_halt && r_reg.pin_level && r_reg.halt_upd &&
          !r_reg.rec_sel) else $error("first power-up defaults wrong");
   a_powerup_clears: assert property (@(posedge clk) disable iff (sys_rst)
      (r_reg.st == RTCMC_OFF && sup_now)
      |=> r_reg.wdog == 8'h00 && !r_reg.freq_test && !r_reg.alarm_en &&
          !r_reg.sqw_en && !r_reg.alarm_bk && r_reg.halt_upd)
      else $error("power-up clears missing");
   a_batt_check: assert property (@(posedge clk) disable iff (sys_rst)
      (r_reg.st == RTCMC_REC && $past(r_reg.st) == RTCMC_OFF && sup_now)
      |-> ##[0:2] !r_reg.batt_req) else $error("power-up check missing");

   // count never passes the chosen length
   a_rec_bound: assert property (@(posedge clk) disable iff (sys_rst)
      (r_reg.st == RTCMC_REC) |-> (r_reg.rec_cnt < rec_len))
      else $error("recovery count overran");
   a_rec_enter: assert property (@(posedge clk) disable iff (sys_rst)
      (r_reg.st == RTCMC_OFF && sup_now)
      |=> (r_reg.st == RTCMC_REC && r_reg.rec_cnt == 32'h0))
      else $error("deselect did not start");
   a_rec_exit: assert property (@(posedge clk) disable iff (sys_rst)
      (r_reg.st == RTCMC_REC && sup_now &&
       r_reg.rec_cnt >= rec_len - 32'h1) |=> (r_reg.st == RTCMC_RUN))
      else $error("deselect overstayed");
   a_supply_drop: assert property (@(posedge clk) disable iff (sys_rst)
      (r_reg.st != RTCMC_OFF && !sup_now) |=> (r_reg.st == RTCMC_OFF))
      else $error("kept running without supply");
   // State code stays one-hot
   a_state_onehot: assert property (@(posedge clk) disable iff (sys_rst)
      $onehot(r_reg.st)) else $error("state code not one-hot");
   a_read_refused: assert property (@(posedge clk) disable iff (sys_rst)
      (rd_stb && r_reg.st != RTCMC_RUN) |=> (rdata == 8'h00))
      else $error("read taken in deselect");
   a_write_refused: assert property (@(posedge clk) disable iff (sys_rst)
      (r_reg.st == RTCMC_REC && wr_stb)
      |=> ($stable(r_reg.wdog) && $stable(r_reg.rec_sel)))
      else $error("write landed in deselect");
   // Read data stand one cycle only
   a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
      !rd_stb |=> (rdata == 8'h00)) else $error("stale read data");
   a_keep_bits: assert property (@(posedge clk) disable iff (sys_rst)
      (r_reg.st == RTCMC_OFF && sup_now && r_reg.ever_up) |=>
      (r_reg.rec_sel == $past(r_reg.rec_sel) &&
       r_reg.osc_halt == $past(r_reg.osc_halt) &&
       r_reg.pin_level == $past(r_reg.pin_level)))
      else $error("retained bits lost at power-up");
   a_first_clears: assert property (@(posedge clk) disable iff (sys_rst)
      (r_reg.st == RTCMC_OFF && sup_now && !r_reg.ever_up) |=>
      (!r_reg.rec_sel && !r_reg.freq_test && !r_reg.alarm_en &&
       !r_reg.alarm_bk && !r_reg.sqw_en && r_reg.wdog == 8'h00))
      else $error("first power-up clears missing");
   a_wdog_cleared: assert property (@(posedge clk) disable iff (sys_rst)
      (r_reg.st == RTCMC_OFF && sup_now) |=> (r_reg.wdog == 8'h00))
      else $error("watchdog byte kept at power-up");
   a_daily_check: assert property (@(posedge clk) disable iff (sys_rst)
      (r_reg.st == RTCMC_RUN && sup_now && !r_reg.batt_req &&
       r_reg.day_cnt >= 48'(CHECK_CYC - 1)) |=> r_reg.batt_req)
      else $error("daily check not requested");
   a_batt_once: assert property (@(posedge clk) disable iff (sys_rst)
      (due && r_reg.st == RTCMC_REC) |=> !r_reg.batt_req)
      else $error("power-up check left pending");
   a_weak_follows: assert property (@(posedge clk) disable iff (sys_rst)
      due |=> (r_reg.batt_weak == $past(bat_now)))
      else $error("weak flag misses check result");
   a_weak_off: assert property (@(posedge clk) disable iff (sys_rst)
      (r_reg.st == RTCMC_OFF) |=> $stable(r_reg.batt_weak))
      else $error("weak flag changed while off");
   // weak event beats a same-cycle clear
   a_irq_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
      (due && bat_now && wr_ok && addr == `RTCMC_ADDR_IST && wdata[0])
      |=> r_reg.ist[0]) else $error("clear beat battery event");
   // Recovery end raises its event
   a_rec_event: assert property (@(posedge clk) disable iff (sys_rst)
      (r_reg.st == RTCMC_REC ##1 r_reg.st == RTCMC_RUN) |-> r_reg.ist[1])
      else $error("recovery event missing");
   // any other function releases the pin
   a_pin_release: assert property (@(posedge clk) disable iff (sys_rst)
      (r_reg.freq_test || r_reg.alarm_en || r_reg.wdog != 8'h00 ||
       r_reg.pin_level) |-> !mf_pin_oe) else $error("pin held low");
   // century write lands when no wrap
   a_cent_write: assert property (@(posedge clk) disable iff (sys_rst)
      (wr_ok && addr == `RTCMC_ADDR_CENT && !year_wrap) |=>
      (r_reg.cent_en == $past(wdata[`RTCMC_BIT_HI]) &&
       r_reg.cent_flag == $past(wdata[`RTCMC_BIT_LO])))
      else $error("century write lost");
   // select write lands in 04h bit 7
   a_sel_write: assert property (@(posedge clk) disable iff (sys_rst)
      (wr_ok && addr == `RTCMC_ADDR_HOUR)
      |=> (r_reg.rec_sel == $past(wdata[`RTCMC_BIT_HI])))
      else $error("recovery select write lost");
endmodule

// ---- rtcmc_host.sv ----
// Host model: register port master plus the board pull-up on the pin.
// Assumes the bench calls wr and rd from one thread, one at a time.
`timescale 1ns/1ps
module rtcmc_host (
   input wire logic clk, // System clock
   output logic [7:0] addr, // Register address
   output logic [7:0] wdata, // Write data
   output logic wr_stb, // Write strobe
   output logic rd_stb, // Read strobe
   input wire logic [7:0] rdata, // Read data
   input wire logic mf_pin_o, // Pin drive level
   input wire logic mf_pin_oe, // Pin pull-low enable
   output wire logic mf_pin // Level seen on the board
);
   assign mf_pin = mf_pin_oe ? mf_pin_o : 1'b1;
   // Idle bus at time zero
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
   end
   // One-cycle write; returns once the taking edge has landed
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
      #1;
   endtask
   // One-cycle read; data stand only in the following cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      d = rdata;
   endtask
endmodule

// ---- rtc_misc_control_and_power_defaults_tb_top.sv ----
// Bench for the RTC misc control block with a host model on the port.
// Assumes shortened recovery and check counts, set at the instance.
`timescale 1ns/1ps
module rtc_misc_control_and_power_defaults_tb_top;
   logic clk, sys_rst, supply_ok, batt_low, year_wrap;
   logic [7:0] addr, wdata, rdata, v;
   logic wr_stb, rd_stb, mf_pin_o, mf_pin_oe, host_enable, irq;
   wire mf_pin;
   int bad_count = 0;
   int n_compared = 0;
   rtcmc_core #(.REC_LONG_CYC(20), .REC_HALT_CYC(30), .REC_SHORT_CYC(5),
      .CHECK_CYC(64'd100)) dut (.clk(clk), .sys_rst(sys_rst),
      .supply_ok(supply_ok), .batt_low(batt_low), .year_wrap(year_wrap),
      .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rdata(rdata), .mf_pin_o(mf_pin_o), .mf_pin_oe(mf_pin_oe),
      .host_enable(host_enable), .irq(irq));
   rtcmc_host host (.clk(clk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .mf_pin_o(mf_pin_o),
      .mf_pin_oe(mf_pin_oe), .mf_pin(mf_pin));
   task automatic give_verdict();
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic timeout();
      bad_count++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      give_verdict();
   endtask
   // Read a register until masked bits match; bounded
   task automatic poll(input logic [7:0] a, m, w);
      for (int i = 0; i < 150; i++) begin
         host.rd(a, v);
         if ((v & m) === w) return;
      end
      timeout();
   endtask
   // Raise supply, count cycles until the port opens
   task automatic power_up(input int lo, input int hi);
      int n;
      n = 0;
      @(posedge clk);
      supply_ok <= 1'b1;
      while (host_enable !== 1'b1) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 200) timeout();
      end
      check(8'(n >= lo && n <= hi), 8'h01);
   endtask
   task automatic power_down();
      int n;
      n = 0;
      @(posedge clk);
      supply_ok <= 1'b0;
      while (host_enable !== 1'b0) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 50) timeout();
      end
   endtask
   task automatic wrap();
      @(posedge clk);
      year_wrap <= 1'b1;
      @(posedge clk);
      year_wrap <= 1'b0;
   endtask
   // Halt set at first power-up, so the longest deselect applies
   task automatic t_first_power();
      power_up(30, 38);
      host.rd(8'h09, v);
      check(v, 8'h00);
      host.rd(8'h0a, v);
      check(v & 8'he0, 8'h00);
      host.rd(8'h08, v);
      check(v & 8'hc0, 8'h80);
      host.rd(8'h04, v);
      check(v & 8'h80, 8'h00);
      host.rd(8'h0c, v);
      check(v & 8'h40, 8'h40);
      $display("done first_power");
   endtask
   // Each other pin function must release the plain output
   task automatic t_pin();
      host.wr(8'h08, 8'h00);
      check({6'h0, mf_pin_oe, mf_pin}, 8'h02);
      host.wr(8'h08, 8'h40);
      check({6'h0, mf_pin_oe, mf_pin}, 8'h01);
      host.wr(8'h08, 8'h80);
      check({6'h0, mf_pin_oe, mf_pin}, 8'h01);
      host.wr(8'h0a, 8'h80);
      host.wr(8'h08, 8'h00);
      check({6'h0, mf_pin_oe, mf_pin}, 8'h01);
      host.wr(8'h0a, 8'h00);
      host.wr(8'h09, 8'h01);
      check({6'h0, mf_pin_oe, mf_pin}, 8'h01);
      host.wr(8'h09, 8'h00);
      check({6'h0, mf_pin_oe, mf_pin}, 8'h02);
      $display("done pin");
   endtask
   task automatic t_century();
      host.wr(8'h03, 8'h80);
      wrap();
      host.rd(8'h03, v);
      check(v & 8'hc0, 8'hc0);
      wrap();
      host.rd(8'h03, v);
      check(v & 8'hc0, 8'h80);
      host.wr(8'h03, 8'h40);
      wrap();
      host.rd(8'h03, v);
      check(v & 8'hc0, 8'h40);
      $display("done century");
   endtask
   // Weak battery found by the daily check, masked then unmasked
   task automatic t_battery();
      host.wr(8'h21, 8'h00);
      host.wr(8'h20, 8'h03);
      @(posedge clk);
      batt_low <= 1'b1;
      poll(8'h0f, 8'h10, 8'h10);
      check({7'h0, irq}, 8'h00);
      host.wr(8'h21, 8'h01);
      check({7'h0, irq}, 8'h01);
      @(posedge clk);
      batt_low <= 1'b0;
      host.rd(8'h0f, v);
      check(v & 8'h10, 8'h10);
      poll(8'h0f, 8'h10, 8'h00);
      host.wr(8'h20, 8'h01);
      check({7'h0, irq}, 8'h00);
      $display("done battery");
   endtask
   // Power cycle on battery: short deselect, retained and cleared bits
   task automatic t_retained();
      host.wr(8'h04, 8'h80);
      host.wr(8'h08, 8'h00);
      host.wr(8'h0a, 8'he0);
      host.wr(8'h09, 8'hff);
      host.wr(8'h0c, 8'h00);
      host.rd(8'h04, v);
      check(v & 8'h80, 8'h80);
      power_down();
      host.wr(8'h08, 8'h80);
      @(posedge clk);
      batt_low <= 1'b1;
      power_up(5, 13);
      host.rd(8'h20, v);
      check(v, 8'h03);
      host.rd(8'h22, v);
      check(v, 8'h04);
      host.rd(8'h0f, v);
      check(v & 8'h10, 8'h10);
      host.rd(8'h08, v);
      check(v & 8'hc0, 8'h00);
      host.rd(8'h04, v);
      check(v & 8'h80, 8'h80);
      host.rd(8'h0c, v);
      check(v & 8'h40, 8'h40);
      host.rd(8'h0a, v);
      check(v & 8'he0, 8'h00);
      host.rd(8'h09, v);
      check(v, 8'h00);
      $display("done retained");
   endtask
   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Reset for 20 cycles, then the scenarios in turn
   initial begin
      sys_rst = 1'b1;
      supply_ok = 1'b0;
      batt_low = 1'b0;
      year_wrap = 1'b0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      t_first_power();
      t_pin();
      t_century();
      t_battery();
      t_retained();
      give_verdict();
   end
endmodule
